// ==== verilog/wdr_top.sv ====
// Watchdog and reset-source control with AXI4-Lite register access
// How it works
// R1: Watchdog counts slow oscillator, 2^8..2^18 division
// R2: Three-bit select picks the division ratio
// R3: Control reloads 0x53 except watchdog warm reset
// R4: Key 10101 disables, 01010 enables watchdog
// R5: Other enable key: fault flag, delayed reset
// R6: Key fault flag cleared only by writing zero
// R7: Software clears counter before timeout elapses
// R8: Running overflow: full reset, set expired flag
// R9: Low-power overflow: expired flag, PC/SP only
// R10: Bad key, clear, halt, pin clear counter
// R11: Power-up zeroes PC, ports start high
// R12: Selected pin low gives full reset, reloads control and pin key
// R13: Pin release adds a delay before running
// R14: Pin key 55 I/O, AA pin, else fault
// R15: Undervoltage gives full reset like pin reset
// R16: Halt sets power-down, clears expired and counter
// R17: Low-power overflow wakes device, starts warm reset
// R18: Every reset except warm restores pin key
// R19: Fault and release delays are parameterised counts
// R20: Counter 18 bits, overflow at selected limit
`timescale 1ns/10ps
module wdr_top import wdr_pkg::*; #(
  parameter int unsigned SOFT_CYC = SOFT_FAULT_CYC,   // Soft fault delay in clocks
  parameter int unsigned REL_CYC  = PIN_RELEASE_CYC,  // Pin release delay in clocks
  parameter int unsigned CNT_W    = 18                // Watchdog counter width
) (
  input  wire logic              i_clk,
  input  wire logic              i_resetn,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0] i_awaddr,
  input  wire logic              i_awvalid,
  output logic                   o_awready,
  input  wire logic [31:0]       i_wdata,
  input  wire logic [3:0]        i_wstrb,
  input  wire logic              i_wvalid,
  output logic                   o_wready,
  output logic [1:0]             o_bresp,
  output logic                   o_bvalid,
  input  wire logic              i_bready,
  input  wire logic [ADDR_W-1:0] i_araddr,
  input  wire logic              i_arvalid,
  output logic                   o_arready,
  output logic [31:0]            o_rdata,
  output logic [1:0]             o_rresp,
  output logic                   o_rvalid,
  input  wire logic              i_rready,
  // Core side
  input  wire logic              i_wd_clear_instr,
  input  wire logic              i_halt_instr,
  input  wire logic              i_low_power,
  // Pins and analog side
  input  wire logic              i_slow_internal_osc,
  input  wire logic              i_ext_nrst_pin,
  input  wire logic              i_low_supply_reset,
  // Reset outputs
  output logic                   o_sys_reset,
  output logic                   o_warm_reset,
  output logic                   o_wake,
  output logic                   o_ports_high,
  output logic                   o_wd_expired_flag,
  output logic                   o_power_down_flag
);
  if (SOFT_CYC < 1 || SOFT_CYC >= (1 << DLY_W) || REL_CYC < 1 || REL_CYC >= (1 << DLY_W))
  begin : g_bad_delay
    $error("Delay counts out of range");
  end

  localparam logic [DLY_W-1:0] SOFT_LAST = DLY_W'(SOFT_CYC - 1);
  localparam logic [DLY_W-1:0] REL_LAST  = DLY_W'(REL_CYC - 1);

  wdr_state_e        state_q;      // Reset sequencer
  logic [DLY_W-1:0]  dly_q;        // Delay counter
  logic [7:0]        wdctl_q;      // watchdog_control
  logic [7:0]        pkey_q;       // pin_function_key
  logic [FLG_W-1:0]  flags_q;      // reset_cause_flags
  logic [FLG_W-1:0]  flag_set;
  logic [FLG_W-1:0]  flag_clr;
  logic              to_q;         // wd_expired_flag
  logic              pdf_q;        // power_down_flag
  logic              warm_q;       // Warm reset pulse
  logic              por_q;        // First cycle after power-up
  logic [2:0]        sync1_q;      // First synchroniser stage, read by stage two only
  logic [2:0]        sync2_q;
  logic              osc_prev_q;   // Delayed oscillator for edge detect
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              rvalid_q;
  logic [1:0]        rresp_q;
  logic [31:0]       rdata_q;
  logic [31:0]       rd_mux;
  logic              rd_hit;
  logic              wr_go;
  logic              rd_go;
  logic              wkey_bad;
  logic              pkey_bad;
  logic              pin_low;
  logic              hold_req;
  logic              uv_s;
  logic              ovf_full;
  logic              ovf_warm;

  wdr_cnt_if cnt_bus ();

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: oscillator, reset pin, low-supply detector
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      // Idle levels: pin high, no undervoltage, oscillator low, so no false source
      sync1_q    <= 3'h4;
      sync2_q    <= 3'h4;
      osc_prev_q <= 1'b0;
    end else begin
      sync1_q    <= {i_ext_nrst_pin, i_low_supply_reset, i_slow_internal_osc};
      sync2_q    <= sync1_q;
      osc_prev_q <= sync2_q[0];
    end
  end

  // Decoded conditions
  assign uv_s     = sync2_q[1];
  assign wkey_bad = (wdctl_q[KEY_MSB:KEY_LSB] != WKEY_ON) &&
                    (wdctl_q[KEY_MSB:KEY_LSB] != WKEY_OFF);          // R4 R5
  assign pkey_bad = (pkey_q != PKEY_IO) && (pkey_q != PKEY_PIN);     // R14
  assign pin_low  = (pkey_q == PKEY_PIN) && !sync2_q[2];             // R12
  assign hold_req = pin_low || uv_s;                                 // R15
  assign ovf_full = cnt_bus.ovf && !i_low_power;
  assign ovf_warm = cnt_bus.ovf && i_low_power;

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog counter
  assign cnt_bus.tick = sync2_q[0] && !osc_prev_q;                   // R1
  assign cnt_bus.run  = wdctl_q[KEY_MSB:KEY_LSB] == WKEY_ON;         // R4
  assign cnt_bus.sel  = wdctl_q[SEL_MSB:0];                          // R2
  // Software must keep clearing it while enabled, else it fires
  assign cnt_bus.clr  = wkey_bad || i_wd_clear_instr || i_halt_instr ||
                        pin_low || (state_q == ST_FULL);             // R10 R16 R7

  wdr_counter #(
    .CNT_W (CNT_W)
  ) u_wdr_counter (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .bus      (cnt_bus)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Reset sequencer; a held source always takes priority over a pending delay
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      state_q <= ST_RUN;
      dly_q   <= '0;
    end else begin
      dly_q <= '0;
      case (state_q)
        ST_RUN: begin
          if (hold_req) begin
            state_q <= ST_HOLD;                                      // R12 R15
          end else if (ovf_full) begin
            state_q <= ST_FULL;                                      // R8
          end else if (wkey_bad || pkey_bad) begin
            state_q <= ST_SOFT;                                      // R5 R14
          end
        end
        ST_SOFT: begin
          if (hold_req) begin
            state_q <= ST_HOLD;
          end else if (ovf_full || dly_q == SOFT_LAST) begin
            state_q <= ST_FULL;                                      // R19
          end else begin
            dly_q <= dly_q + 1'b1;
          end
        end
        ST_HOLD: begin
          if (!hold_req) begin
            state_q <= ST_REL;
          end
        end
        ST_REL: begin
          if (hold_req) begin
            state_q <= ST_HOLD;
          end else if (dly_q == REL_LAST) begin
            state_q <= ST_FULL;                                      // R13 R19
          end else begin
            dly_q <= dly_q + 1'b1;
          end
        end
        ST_FULL: begin
          state_q <= ST_RUN;
        end
        default: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control and pin key; reload at the end of every full reset, not on warm reset
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      wdctl_q <= CTRL_RST;                                           // R3
      pkey_q  <= PKEY_RST;                                           // R14
    end else if (state_q == ST_FULL) begin
      wdctl_q <= CTRL_RST;                                           // R3
      pkey_q  <= PKEY_RST;                                           // R18
    end else if (wr_go && i_wstrb[0]) begin
      if (i_awaddr == OFS_CTRL) begin
        wdctl_q <= i_wdata[7:0];
      end
      if (i_awaddr == OFS_PKEY) begin
        pkey_q <= i_wdata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cause flags: hardware set beats a software clear in the same cycle
  always_comb begin
    flag_set           = '0;
    flag_set[FLG_WKEY] = (state_q == ST_RUN) && wkey_bad;            // R5
    flag_set[FLG_PKEY] = (state_q == ST_RUN) && pkey_bad;
    flag_set[FLG_UV]   = (state_q == ST_RUN) && uv_s;
    flag_clr           = '0;
    if (wr_go && i_wstrb[0] && i_awaddr == OFS_CAUSE) begin
      flag_clr = ~i_wdata[FLG_W-1:0];                                // R6
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      flags_q <= '0;
    end else begin
      flags_q <= flag_set | (flags_q & ~flag_clr);                   // R6
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Expired and power-down flags; survive pin, undervoltage and watchdog resets
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      to_q  <= 1'b0;
      pdf_q <= 1'b0;
    end else if (cnt_bus.ovf) begin
      to_q  <= 1'b1;                                                 // R8 R9
      pdf_q <= pdf_q || i_low_power;
    end else if (i_halt_instr) begin
      to_q  <= 1'b0;                                                 // R16
      pdf_q <= 1'b1;
    end else if (i_wd_clear_instr) begin
      pdf_q <= 1'b0;
    end
  end

  // Warm reset and wake pulse, power-up port init
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      warm_q <= 1'b0;
      por_q  <= 1'b1;                                                // R11
    end else begin
      warm_q <= ovf_warm;                                            // R9 R17
      por_q  <= 1'b0;
    end
  end

  assign o_sys_reset       = state_q[2] || state_q[3] || state_q[4]; // R12 R11
  assign o_warm_reset      = warm_q;
  assign o_wake            = warm_q;                                 // R17
  assign o_ports_high      = por_q;
  assign o_wd_expired_flag = to_q;
  assign o_power_down_flag = pdf_q;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite: write address and data taken together, one answer at a time
  assign wr_go     = i_awvalid && i_wvalid && !bvalid_q;
  assign o_awready = wr_go;
  assign o_wready  = wr_go;
  assign rd_go     = i_arvalid && !rvalid_q;
  assign o_arready = !rvalid_q;

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (i_awaddr[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
    end else if (i_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Read mux; upper bits read as zero, unaligned reads fail
  always_comb begin
    rd_mux = '0;
    rd_hit = 1'b1;
    case (i_araddr)
      OFS_CTRL:  rd_mux[7:0]       = wdctl_q;
      OFS_CAUSE: rd_mux[FLG_W-1:0] = flags_q;
      OFS_PKEY:  rd_mux[7:0]       = pkey_q;
      OFS_STAT: begin
        rd_mux[STAT_TO]  = to_q;
        rd_mux[STAT_PDF] = pdf_q;
      end
      default:   rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      rvalid_q <= 1'b0;
      rresp_q  <= RESP_OKAY;
      rdata_q  <= '0;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      rdata_q  <= rd_mux;
    end else if (i_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign o_bvalid = bvalid_q;
  assign o_bresp  = bresp_q;
  assign o_rvalid = rvalid_q;
  assign o_rresp  = rresp_q;
  assign o_rdata  = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_soft_done;
    (state_q == ST_SOFT) && (dly_q == SOFT_LAST) && !hold_req;
  endsequence

  property p_soft_delay;
    s_soft_done |=> (state_q == ST_FULL) ##1 (wdctl_q == CTRL_RST) && (pkey_q == PKEY_RST);
  endproperty
  a_soft_delay: assert property (p_soft_delay) else $error("Soft reset late"); // R19

  property p_key_fault;
    (state_q == ST_RUN) && wkey_bad && !hold_req && !cnt_bus.ovf |=>
      flags_q[FLG_WKEY] && (state_q == ST_SOFT);
  endproperty
  a_key_fault: assert property (p_key_fault) else $error("Key fault missed"); // R5

  property p_flag_sticky;
    flags_q[FLG_WKEY] && !flag_clr[FLG_WKEY] |=> flags_q[FLG_WKEY];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("Fault flag lost"); // R6

  property p_full_ovf;
    ovf_full && (state_q == ST_RUN) && !hold_req |=> (state_q == ST_FULL) && to_q && o_sys_reset;
  endproperty
  a_full_ovf: assert property (p_full_ovf) else $error("Overflow reset missed"); // R8

  property p_warm_ovf;
    ovf_warm |=> o_warm_reset && o_wake && to_q && pdf_q && $stable(wdctl_q);
  endproperty
  a_warm_ovf: assert property (p_warm_ovf) else $error("Warm reset wrong"); // R9

  property p_halt;
    i_halt_instr && !cnt_bus.ovf |=> pdf_q && !to_q;
  endproperty
  a_halt: assert property (p_halt) else $error("Halt flags wrong"); // R16

  sequence s_pin_hold;
    (state_q == ST_HOLD) && hold_req;
  endsequence

  property p_pin_hold;
    (state_q == ST_RUN) && pin_low |=> s_pin_hold ##0 o_sys_reset;
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("Pin reset missed"); // R12

  property p_release;
    (state_q == ST_HOLD) && !hold_req |=> (state_q == ST_REL) && (dly_q == '0) && o_sys_reset;
  endproperty
  a_release: assert property (p_release) else $error("Release delay skipped"); // R13

  property p_pkey_reload;
    (state_q == ST_FULL) |=> (pkey_q == PKEY_RST) && (wdctl_q == CTRL_RST) && !o_sys_reset;
  endproperty
  a_pkey_reload: assert property (p_pkey_reload) else $error("Keys not reloaded"); // R18 R3

  property p_uv;
    (state_q == ST_RUN) && uv_s |=> (state_q == ST_HOLD) && flags_q[FLG_UV];
  endproperty
  a_uv: assert property (p_uv) else $error("Undervoltage reset missed"); // R15
endmodule // wdr_top

// ==== common/wdr_pkg.sv ====
// Package: constants, state encoding and lookups for the watchdog and reset control block
package wdr_pkg;
  // Clock and delay timing
  localparam int unsigned CLK_PERIOD_NS        = 20;
  localparam int unsigned SOFT_FAULT_DELAY_NS  = 50000;   // Soft fault delay, plain default
  localparam int unsigned PIN_RELEASE_DELAY_NS = 100000;  // Pin release delay, plain default
  // Least times round up to whole cycles
  localparam int unsigned SOFT_FAULT_CYC  = (SOFT_FAULT_DELAY_NS + CLK_PERIOD_NS - 1)
                                            / CLK_PERIOD_NS;
  localparam int unsigned PIN_RELEASE_CYC = (PIN_RELEASE_DELAY_NS + CLK_PERIOD_NS - 1)
                                            / CLK_PERIOD_NS;
  localparam int unsigned DLY_W = 16;                     // Width of the delay counter
  localparam int unsigned WD_MIN_CNT_W = 18;              // Longest timeout is 2^18 ticks

  // Register byte offsets on the AXI4-Lite bus
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] OFS_CTRL  = 4'h0;                // watchdog_control
  localparam logic [3:0] OFS_CAUSE = 4'h4;                // reset_cause_flags
  localparam logic [3:0] OFS_PKEY  = 4'h8;                // pin_function_key
  localparam logic [3:0] OFS_STAT  = 4'hc;                // Status flags, read only

  // Reset values and key encodings
  localparam logic [7:0] CTRL_RST = 8'h53;
  localparam logic [7:0] PKEY_RST = 8'h55;
  localparam logic [7:0] PKEY_IO  = 8'h55;                // Shared I/O function
  localparam logic [7:0] PKEY_PIN = 8'haa;                // External reset pin
  localparam logic [4:0] WKEY_OFF = 5'h15;
  localparam logic [4:0] WKEY_ON  = 5'h0a;
  localparam int unsigned KEY_LSB = 3;                    // Enable key sits in bits 7..3
  localparam int unsigned KEY_MSB = 7;
  localparam int unsigned SEL_MSB = 2;                    // Timeout select sits in bits 2..0

  // Field positions in reset_cause_flags and status
  localparam int unsigned FLG_WKEY = 0;                   // wd_key_fault_flag
  localparam int unsigned FLG_LKEY = 1;                   // undervolt_key_fault_flag
  localparam int unsigned FLG_UV   = 2;                   // undervoltage_flag
  localparam int unsigned FLG_PKEY = 3;                   // pin_key_fault_flag
  localparam int unsigned FLG_W    = 4;
  localparam int unsigned STAT_TO  = 0;                   // wd_expired_flag
  localparam int unsigned STAT_PDF = 1;                   // power_down_flag

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Reset sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_RUN  = 5'h01,                                      // Normal operation
    ST_SOFT = 5'h02,                                      // Waiting out the soft fault delay
    ST_HOLD = 5'h04,                                      // Reset source held active
    ST_REL  = 5'h08,                                      // Pin release delay
    ST_FULL = 5'h10                                       // One-cycle full reset
  } wdr_state_e;

  // Timeout select to power of two
  function automatic logic [4:0] wdr_shift(input logic [2:0] sel);
    case (sel)
      3'h0:    wdr_shift = 5'h08;
      3'h1:    wdr_shift = 5'h0a;
      3'h2:    wdr_shift = 5'h0c;
      3'h3:    wdr_shift = 5'h0e;
      3'h4:    wdr_shift = 5'h0f;
      3'h5:    wdr_shift = 5'h10;
      3'h6:    wdr_shift = 5'h11;
      default: wdr_shift = 5'h12;
    endcase
  endfunction
endpackage

// ==== common/wdr_cnt_if.sv ====
// Interface between the reset sequencer and the watchdog counter
`timescale 1ns/10ps
interface wdr_cnt_if;
  logic       tick;   // One slow oscillator period elapsed
  logic       clr;    // Clear the count
  logic       run;    // Watchdog enabled
  logic [2:0] sel;    // Timeout select
  logic       ovf;    // Overflow pulse
  modport ctl (output tick, output clr, output run, output sel, input ovf);
  modport cnt (input tick, input clr, input run, input sel, output ovf);
endinterface

// ==== verilog/wdr_counter.sv ====
// Watchdog counter with selectable power-of-two overflow
`timescale 1ns/10ps
module wdr_counter import wdr_pkg::*; #(
  parameter int unsigned CNT_W = 18
) (
  input  wire logic i_clk,
  input  wire logic i_resetn,
  wdr_cnt_if.cnt    bus
);
  if (CNT_W < WD_MIN_CNT_W) begin : g_bad_width
    $error("Counter too narrow for the longest timeout");
  end

  logic [CNT_W-1:0] cnt_q;   // Slow ticks since last clear
  logic             ovf_q;   // Overflow pulse
  logic [CNT_W-1:0] last;    // Final count before overflow
  logic [CNT_W-1:0] ones;

  assign ones = '1;
  assign last = ones >> (CNT_W - int'(wdr_shift(bus.sel)));  // R2 R20

  // Count slow ticks; a clear always wins so a late clear never lets it slip
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      cnt_q <= '0;
    end else if (bus.clr) begin
      cnt_q <= '0;                                           // R10
    end else if (bus.run && bus.tick) begin
      cnt_q <= (cnt_q == last) ? '0 : cnt_q + 1'b1;          // R1 R20
    end
  end

  // Overflow pulse on the tick that completes 2^n periods
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      ovf_q <= 1'b0;
    end else begin
      ovf_q <= !bus.clr && bus.run && bus.tick && (cnt_q == last);  // R20
    end
  end

  assign bus.ovf = ovf_q;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  property p_cnt_clear;
    bus.clr |=> (cnt_q == '0) && !ovf_q;
  endproperty
  a_cnt_clear: assert property (p_cnt_clear) else $error("Counter not cleared"); // R10

  property p_ovf_limit;
    ovf_q |-> ($past(cnt_q) == $past(last)) && (cnt_q == '0) && $past(bus.tick);
  endproperty
  a_ovf_limit: assert property (p_ovf_limit) else $error("Overflow at wrong count"); // R20
endmodule // wdr_counter

// ==== verif/wdr_core_model.sv ====
// CPU core model that issues the watchdog clear and halt instructions
`timescale 1ns/10ps
module wdr_core_model (
  input  wire logic i_clk,
  output logic      o_clear,
  output logic      o_halt
);
  // Idle until the bench asks for an instruction
  initial begin
    o_clear = 1'b0;
    o_halt  = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // One-cycle clear; the bench issues it after the low-power overflow to clear power_down_flag
  task automatic pulse_clear();
    @(posedge i_clk) o_clear <= 1'b1;
    @(posedge i_clk) o_clear <= 1'b0;
  endtask
  // One-cycle halt; the block sees it at the second edge
  task automatic pulse_halt();
    @(posedge i_clk) o_halt <= 1'b1;
    @(posedge i_clk) o_halt <= 1'b0;
  endtask
endmodule // wdr_core_model

// ==== verif/wdr_top_test.sv ====
// Self-checking bench for the watchdog and reset control block
`timescale 1ns/10ps
module wdr_top_test;
  logic        i_clk, i_resetn, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic [3:0]  i_awaddr, i_araddr, i_wstrb;
  logic [31:0] i_wdata, o_rdata;
  logic [1:0]  o_bresp, o_rresp;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic        i_wd_clear_instr, i_halt_instr, i_low_power, i_slow_internal_osc;
  logic        i_ext_nrst_pin, i_low_supply_reset, o_sys_reset, o_warm_reset, o_wake;
  logic        o_ports_high, o_wd_expired_flag, o_power_down_flag;
  logic [5:0]  ev;         // Signals that bounded waits watch
  logic [9:0]  exp_q[$];   // Expected {rresp, rdata} per read
  int          miscompares, cmp_count, n;
  assign ev = {o_rvalid, o_arready, o_bvalid, o_awready && o_wready, o_warm_reset, o_sys_reset};
  // Short delays keep the run brief
  wdr_top #(.SOFT_CYC(4), .REL_CYC(6)) u_wdr_top (.i_clk, .i_resetn, .i_awaddr,
    .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp,
    .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp,
    .o_rvalid, .i_rready, .i_wd_clear_instr, .i_halt_instr, .i_low_power,
    .i_slow_internal_osc, .i_ext_nrst_pin, .i_low_supply_reset, .o_sys_reset,
    .o_warm_reset, .o_wake, .o_ports_high, .o_wd_expired_flag, .o_power_down_flag);
  wdr_core_model u_wdr_core_model (.i_clk, .o_clear(i_wd_clear_instr),
    .o_halt(i_halt_instr));
  // 50 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  ////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input string nm, input logic [9:0] got, input logic [9:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s exp %h got %h", nm, exp, got);
    end
  endtask
  // Verdict and end of run
  task automatic results();
    if (miscompares == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Bounded wait for ev[k] to equal v; n holds the cycles spent
  task automatic wt(input int k, input logic v);
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (ev[k] !== v && n < 9000);
    if (n >= 9000) begin
      miscompares++;
      results();
    end
  endtask
  // Register write; upper data bits are random since they are ignored
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    i_awaddr  <= a;
    i_wdata   <= {24'($urandom), d};
    i_awvalid <= 1'b1;
    i_wvalid  <= 1'b1;
    wt(2, 1'b1);
    i_awvalid <= 1'b0;
    i_wvalid  <= 1'b0;
    i_bready  <= 1'b1;
    wt(3, 1'b1);
    chk("bresp", o_bresp, {a[1:0] != 2'h0, 1'b0});
    i_bready  <= 1'b0;
  endtask
  // Register read; the monitor compares the answer
  task automatic rd(input logic [3:0] a, input logic [9:0] e);
    exp_q.push_back(e);
    i_araddr  <= a;
    i_arvalid <= 1'b1;
    wt(4, 1'b1);
    i_arvalid <= 1'b0;
    i_rready  <= 1'b1;
    wt(5, 1'b1);
    i_rready  <= 1'b0;
  endtask
  // Slow oscillator periods of four clocks each; it stands still otherwise
  task automatic ticks(input int k);
    repeat (k) begin
      i_slow_internal_osc <= 1'b1;
      repeat (2) @(posedge i_clk);
      i_slow_internal_osc <= 1'b0;
      repeat (2) @(posedge i_clk);
    end
  endtask
  // Read monitor takes the oldest note off the queue
  always @(posedge i_clk) begin
    if (o_rvalid && i_rready) begin
      chk("rdata", {o_rresp, o_rdata[7:0]}, exp_q.pop_front());
      chk("rd_hi", |o_rdata[31:8], 0);
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(32'hf4af));
    {i_resetn, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = '0;
    {i_low_power, i_slow_internal_osc, i_low_supply_reset} = '0;
    i_ext_nrst_pin = 1'b1;
    {i_awaddr, i_araddr, i_wdata} = '0;
    i_wstrb = 4'hf;
    miscompares = 0;
    cmp_count = 0;
    repeat (16) @(posedge i_clk);
    i_resetn <= 1'b1;
    @(negedge i_clk);
    chk("ports", o_ports_high, 1);
    @(negedge i_clk);
    chk("ports_off", {o_ports_high, o_sys_reset}, 0);
    @(posedge i_clk);
    rd(4'h0, 10'h053);
    rd(4'h8, 10'h055);
    // Unaligned access answers an error and writes nothing
    wr(4'h9, 8'h12);
    rd(4'h9, 10'h200);
    rd(4'h8, 10'h055);
    // Shortest timeout overflows on the 256th tick
    wr(4'h0, 8'h50);
    ticks(255);
    chk("early", o_sys_reset, 0);
    fork
      ticks(1);
      wt(0, 1'b1);
    join
    chk("expired", o_wd_expired_flag, 1);
    rd(4'h0, 10'h053);
    u_wdr_core_model.pulse_halt();
    @(posedge i_clk);
    chk("halt", {o_power_down_flag, o_wd_expired_flag}, 2);
    // Overflow in low power gives a warm reset only
    wr(4'h0, 8'h50);
    i_low_power <= 1'b1;
    fork
      ticks(256);
      wt(1, 1'b1);
    join
    chk("wake", {o_wake, o_sys_reset}, 2);
    chk("exp_lp", {o_wd_expired_flag, o_power_down_flag}, 3);
    rd(4'h0, 10'h050);
    i_low_power <= 1'b0;
    u_wdr_core_model.pulse_clear();
    @(posedge i_clk);
    chk("pd_clr", o_power_down_flag, 0);
    // Halt clears the expired flag so the disabled run starts clean
    u_wdr_core_model.pulse_halt();
    // Disabled watchdog never expires
    wr(4'h0, 8'ha8);
    ticks(300);
    chk("off", {o_wd_expired_flag, o_sys_reset}, 0);
    // Bad enable key: delayed reset and sticky flag
    wr(4'h0, 8'h00);
    wt(0, 1'b1);
    chk("soft", n == 5, 1);
    rd(4'h4, 10'h001);
    rd(4'h0, 10'h053);
    wr(4'h4, 8'hff);
    rd(4'h4, 10'h001);
    wr(4'h4, 8'h00);
    rd(4'h4, 10'h000);
    // Pin reset with release delay
    wr(4'h8, 8'haa);
    i_ext_nrst_pin <= 1'b0;
    wt(0, 1'b1);
    i_ext_nrst_pin <= 1'b1;
    wt(0, 1'b0);
    chk("release", n == 11, 1);
    rd(4'h8, 10'h055);
    // Undervoltage and bad pin key
    i_low_supply_reset <= 1'b1;
    wt(0, 1'b1);
    i_low_supply_reset <= 1'b0;
    wt(0, 1'b0);
    rd(4'h4, 10'h004);
    wr(4'h8, 8'h12);
    wt(0, 1'b1);
    rd(4'h4, 10'h00c);
    results();
  end
endmodule // wdr_top_test
